//--- src/isr_pkg.sv
// Package with bit positions, reset values and sizes for the status reporting block
package isr_pkg;
   localparam int          QUES_CAL_LOST      = 8;
   localparam int          QUES_TRIG_FAST     = 9;
   localparam int          QUES_BUF_OVFL      = 10;
   localparam int          QUES_OVERVOLT      = 11;
   localparam int          QUES_MEM_OVFL      = 12;
   localparam int          QUES_SETUP_CHG     = 13;
   localparam int          OPER_CALIBRATING   = 0;
   localparam int          OPER_MEASURING     = 4;
   localparam int          OPER_SCAN_DONE     = 8;
   localparam int          OPER_PLUGON_TRIG   = 9;
   localparam int          OPER_HALF_FULL     = 10;
   localparam int          OPER_ALG_IRQ       = 11;
   localparam int          STD_OP_COMPLETE    = 0;
   localparam int          STD_REQ_CONTROL    = 1;
   localparam int          STD_QUERY_ERR      = 2;
   localparam int          STD_DEV_ERR        = 3;
   localparam int          STD_EXEC_ERR       = 4;
   localparam int          STD_CMD_ERR        = 5;
   localparam int          STD_USER_REQ       = 6;
   localparam int          STD_POWER_ON       = 7;
   localparam int          STB_QUES           = 3;
   localparam int          STB_MAV            = 4;
   localparam int          STB_STD            = 5;
   localparam int          STB_OPER           = 7;
   localparam logic [16:0] BUF_OVFL_LIMIT     = 17'd65024;
   localparam logic [16:0] BUF_HALF_LEVEL     = 17'd32768;
   localparam logic [15:0] PTR_RESET          = 16'hFFFF;
   localparam logic [15:0] NTR_RESET          = 16'h0000;
   localparam logic [15:0] ENABLE_RESET       = 16'h0000;
   localparam logic [15:0] QUES_USED_MASK     = 16'h3F00;
   localparam logic [15:0] OPER_USED_MASK     = 16'h0D11;
   localparam logic [7:0]  STD_USED_MASK      = 8'hBD;
   typedef enum logic [2:0] {
      ISR_CAL_IDLE = 3'h1,
      ISR_CAL_RUN  = 3'h2,
      ISR_CAL_DONE = 3'h4
   } isr_cal_state_t;
endpackage : isr_pkg

//--- src/isr_group_if.sv
// Interface between the status reporting top and one event group
`timescale 1ns/10ps
interface isr_group_if;
   logic [15:0] cond;
   logic [15:0] ptr;
   logic [15:0] ntr;
   logic [15:0] enable;
   logic        read_clr;
   logic        clear_all;
   logic [15:0] event_bits;
   logic        summary;
   modport top (output cond, output ptr, output ntr, output enable, output read_clr, output clear_all,
                input event_bits, input summary);
   modport grp (input cond, input ptr, input ntr, input enable, input read_clr, input clear_all,
                output event_bits, output summary);
endinterface : isr_group_if

//--- src/isr_event_group.sv
// One status group: transition filters, latched events and summary
`timescale 1ns/10ps
module isr_event_group (
   input wire logic    sys_clk,
   input wire logic    nrst,
   input wire logic    clk_en,
   isr_group_if.grp    gi
);
   logic [15:0] cond_prev_reg;
   logic [15:0] event_reg;
   logic [15:0] event_next;

   // Per bit filter: set wins over a read clear in the same cycle
   genvar b;
   generate
      for (b = 0; b < 16; b++) begin : g_bit
         always_comb begin
            event_next[b] = (gi.read_clr || gi.clear_all) ? 1'b0 : event_reg[b];
            if ((!cond_prev_reg[b] && gi.cond[b] && gi.ptr[b]) ||
                (cond_prev_reg[b] && !gi.cond[b] && gi.ntr[b])) begin
               event_next[b] = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cond_prev_reg <= 16'h0000;
      end else if (clk_en) begin
         cond_prev_reg <= gi.cond;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         event_reg <= 16'h0000;
      end else if (clk_en) begin
         event_reg <= event_next;
      end
   end

   assign gi.event_bits = event_reg;
   assign gi.summary    = |(event_reg & gi.enable);

   a_rise_latches: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && !cond_prev_reg[0] && gi.cond[0] && gi.ptr[0] |=> event_reg[0])
      else $error("rising edge with filter set did not latch");
   a_event_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
      !gi.read_clr && !gi.clear_all |=> ((event_reg & $past(event_reg)) == $past(event_reg)))
      else $error("latched event dropped without a clear");
endmodule : isr_event_group

//--- src/isr_status_top.sv
// Status reporting top: conditions, three event groups and the status byte
// Functional notes
// - Combine group summaries into one status byte
// - Calibration checksum failure at a reset command or power on sets questionable bit 8
// - Trigger during unfinished scan sets bit 9
// - Buffer store at count 65024 or more sets bit 10
// - Overvoltage sets bit 11, opens relays till reset
// - Acquisitions beyond mapped memory set bit 12
// - Setup change sets bit 13; reset sets it
// - Calibrating bit: tare/setup set, queries clear
// - Measuring bit follows trigger initiated versus idle
// - Each finished scan pass sets operation bit 8
// - Operation bit 9 reserved, never driven
// - Operation bit 10 when buffer holds 32768
// - Algorithm interrupt call sets operation bit 11
// - Operation complete sets standard event bit 0
// - Empty queue read or lost data sets bit 2
// - Device error sets standard event bit 3
// - Execution error sets standard event bit 4
// - Command error sets standard event bit 5
// - Power applied sets standard event bit 7
// - Transition filters choose which edges latch events
// - Events clear on read, preset, clear, reset
// - Power-on filters: positive all ones, negative zero
// - Summaries in status byte bits 3, 7, 5
`timescale 1ns/10ps
module isr_status_top (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        power_on_pulse,
   input  wire logic        reset_cmd,
   input  wire logic        preset_cmd,
   input  wire logic        clear_status_cmd,
   input  wire logic        cal_checksum_fail,
   input  wire logic        trigger_event,
   input  wire logic        scan_active,
   input  wire logic        scan_pass_done,
   input  wire logic        buffer_store,
   input  wire logic [16:0] buffer_count,
   input  wire logic        acq_mem_overflow,
   input  wire logic        overvoltage_detect,
   input  wire logic        protect_enabled,
   input  wire logic        setup_changed,
   input  wire logic        cal_setup_done,
   input  wire logic        tare_calibration_command,
   input  wire logic        setup_cal_command,
   input  wire logic        cal_query,
   input  wire logic        self_cal_start,
   input  wire logic        self_cal_done,
   input  wire logic        trigger_initiated,
   input  wire logic        trigger_idle,
   input  wire logic        alg_interrupt,
   input  wire logic        opc_done,
   input  wire logic        query_error,
   input  wire logic        device_error,
   input  wire logic        execution_error,
   input  wire logic        command_error,
   input  wire logic        output_queue_avail,
   input  wire logic [15:0] ques_ptr_wr_data,
   input  wire logic        ques_ptr_wr,
   input  wire logic [15:0] ques_ntr_wr_data,
   input  wire logic        ques_ntr_wr,
   input  wire logic [15:0] ques_enable_wr_data,
   input  wire logic        ques_enable_wr,
   input  wire logic [15:0] oper_ptr_wr_data,
   input  wire logic        oper_ptr_wr,
   input  wire logic [15:0] oper_ntr_wr_data,
   input  wire logic        oper_ntr_wr,
   input  wire logic [15:0] oper_enable_wr_data,
   input  wire logic        oper_enable_wr,
   input  wire logic [7:0]  std_enable_wr_data,
   input  wire logic        std_enable_wr,
   input  wire logic        ques_event_read,
   input  wire logic        oper_event_read,
   input  wire logic        std_event_read,
   output logic      [15:0] questionable_conditions,
   output logic      [15:0] operation_conditions,
   output logic      [15:0] ques_event_data,
   output logic      [15:0] oper_event_data,
   output logic      [7:0]  standard_events,
   output logic      [7:0]  status_byte,
   output logic             error_log_pulse,
   output logic             input_relays_open
);
   isr_group_if ques_if ();
   isr_group_if oper_if ();

   logic [15:0]         ques_cond_reg;
   logic [15:0]         oper_cond_reg;
   logic [15:0]         ques_ptr_reg;
   logic [15:0]         ques_ntr_reg;
   logic [15:0]         ques_enable_reg;
   logic [15:0]         oper_ptr_reg;
   logic [15:0]         oper_ntr_reg;
   logic [15:0]         oper_enable_reg;
   logic [7:0]          std_enable_reg;
   logic [7:0]          std_event_reg;
   logic [7:0]          std_event_next;
   logic                relay_open_reg;
   logic                error_log_reg;
   logic [7:0]          status_byte_reg;
   logic                clear_all;
   isr_pkg::isr_cal_state_t cal_state_reg;

   // Reset commands clear events; filters keep host settings except at power on
   assign clear_all = reset_cmd || preset_cmd || clear_status_cmd;

   // Self calibration sequence holds the calibrating bit while running
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cal_state_reg <= isr_pkg::ISR_CAL_IDLE;
      end else if (clk_en) begin
         case (cal_state_reg)
            isr_pkg::ISR_CAL_IDLE: begin
               if (self_cal_start) begin
                  cal_state_reg <= isr_pkg::ISR_CAL_RUN;
               end
            end
            isr_pkg::ISR_CAL_RUN: begin
               if (self_cal_done) begin
                  cal_state_reg <= isr_pkg::ISR_CAL_DONE;
               end
            end
            default: begin
               cal_state_reg <= isr_pkg::ISR_CAL_IDLE;
            end
         endcase
      end
   end

   // Questionable conditions; sticky until cleared by reset command or power on, except setup change, which those set and cal_setup_done clears
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ques_cond_reg <= 16'h2000;
      end else if (clk_en) begin
         if (reset_cmd || power_on_pulse) begin
            ques_cond_reg <= 16'h0000;
            ques_cond_reg[isr_pkg::QUES_SETUP_CHG] <= 1'b1;
            ques_cond_reg[isr_pkg::QUES_CAL_LOST]  <= cal_checksum_fail;
         end else begin
            if (trigger_event && scan_active) begin
               ques_cond_reg[isr_pkg::QUES_TRIG_FAST] <= 1'b1;
            end
            if (buffer_store && (buffer_count >= isr_pkg::BUF_OVFL_LIMIT)) begin
               ques_cond_reg[isr_pkg::QUES_BUF_OVFL] <= 1'b1;
            end
            if (overvoltage_detect) begin
               ques_cond_reg[isr_pkg::QUES_OVERVOLT] <= 1'b1;
            end
            if (acq_mem_overflow) begin
               ques_cond_reg[isr_pkg::QUES_MEM_OVFL] <= 1'b1;
            end
            if (setup_changed) begin
               ques_cond_reg[isr_pkg::QUES_SETUP_CHG] <= 1'b1;
            end else if (cal_setup_done) begin
               ques_cond_reg[isr_pkg::QUES_SETUP_CHG] <= 1'b0;
            end
         end
      end
   end

   // Relays stay open until a reset command even if overvoltage goes away
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         relay_open_reg <= 1'b0;
      end else if (clk_en) begin
         if (overvoltage_detect && protect_enabled) begin
            relay_open_reg <= 1'b1;
         end else if (reset_cmd) begin
            relay_open_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         error_log_reg <= 1'b0;
      end else if (clk_en) begin
         error_log_reg <= ((reset_cmd || power_on_pulse) && cal_checksum_fail) || overvoltage_detect;
      end
   end

   // Operation conditions; bit 9 left at zero for future plug-ons
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         oper_cond_reg <= 16'h0000;
      end else if (clk_en) begin
         if (tare_calibration_command || setup_cal_command || self_cal_start) begin
            oper_cond_reg[isr_pkg::OPER_CALIBRATING] <= 1'b1;
         end else if (cal_query || (cal_state_reg == isr_pkg::ISR_CAL_DONE)) begin
            oper_cond_reg[isr_pkg::OPER_CALIBRATING] <= 1'b0;
         end
         if (trigger_initiated) begin
            oper_cond_reg[isr_pkg::OPER_MEASURING] <= 1'b1;
         end else if (trigger_idle) begin
            oper_cond_reg[isr_pkg::OPER_MEASURING] <= 1'b0;
         end
         oper_cond_reg[isr_pkg::OPER_SCAN_DONE]   <= scan_pass_done;
         oper_cond_reg[isr_pkg::OPER_PLUGON_TRIG] <= 1'b0;
         oper_cond_reg[isr_pkg::OPER_HALF_FULL]   <= (buffer_count >= isr_pkg::BUF_HALF_LEVEL);
         oper_cond_reg[isr_pkg::OPER_ALG_IRQ]     <= alg_interrupt;
      end
   end

   // Filters and enables; power on restores filter defaults
   always_ff @(posedge sys_clk) begin
      // Power on is a reset of the filters, but only when the clock enable lets state move
      if (!nrst || (clk_en && power_on_pulse)) begin
         ques_ptr_reg    <= isr_pkg::PTR_RESET;
         ques_ntr_reg    <= isr_pkg::NTR_RESET;
         oper_ptr_reg    <= isr_pkg::PTR_RESET;
         oper_ntr_reg    <= isr_pkg::NTR_RESET;
         ques_enable_reg <= isr_pkg::ENABLE_RESET;
         oper_enable_reg <= isr_pkg::ENABLE_RESET;
         std_enable_reg  <= 8'h00;
      end else if (clk_en) begin
         if (ques_ptr_wr) begin
            ques_ptr_reg <= ques_ptr_wr_data;
         end
         if (ques_ntr_wr) begin
            ques_ntr_reg <= ques_ntr_wr_data;
         end
         if (ques_enable_wr) begin
            ques_enable_reg <= ques_enable_wr_data;
         end
         if (oper_ptr_wr) begin
            oper_ptr_reg <= oper_ptr_wr_data;
         end
         if (oper_ntr_wr) begin
            oper_ntr_reg <= oper_ntr_wr_data;
         end
         if (oper_enable_wr) begin
            oper_enable_reg <= oper_enable_wr_data;
         end
         if (std_enable_wr) begin
            std_enable_reg <= std_enable_wr_data;
         end
      end
   end

   assign ques_if.cond      = ques_cond_reg & isr_pkg::QUES_USED_MASK;
   assign ques_if.ptr       = ques_ptr_reg;
   assign ques_if.ntr       = ques_ntr_reg;
   assign ques_if.enable    = ques_enable_reg;
   assign ques_if.read_clr  = ques_event_read && clk_en;
   assign ques_if.clear_all = clear_all;
   assign oper_if.cond      = oper_cond_reg & isr_pkg::OPER_USED_MASK;
   assign oper_if.ptr       = oper_ptr_reg;
   assign oper_if.ntr       = oper_ntr_reg;
   assign oper_if.enable    = oper_enable_reg;
   assign oper_if.read_clr  = oper_event_read && clk_en;
   assign oper_if.clear_all = clear_all;

   isr_event_group u_ques (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .gi      (ques_if.grp)
   );

   isr_event_group u_oper (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .gi      (oper_if.grp)
   );

   // Standard events latch until read or cleared; set beats a read clear in the same cycle
   always_comb begin
      std_event_next = (std_event_read || clear_all) ? 8'h00 : std_event_reg;
      std_event_next[isr_pkg::STD_OP_COMPLETE] = std_event_next[isr_pkg::STD_OP_COMPLETE] | opc_done;
      std_event_next[isr_pkg::STD_QUERY_ERR]   = std_event_next[isr_pkg::STD_QUERY_ERR] | query_error;
      std_event_next[isr_pkg::STD_DEV_ERR]     = std_event_next[isr_pkg::STD_DEV_ERR] | device_error;
      std_event_next[isr_pkg::STD_EXEC_ERR]    = std_event_next[isr_pkg::STD_EXEC_ERR] | execution_error;
      std_event_next[isr_pkg::STD_CMD_ERR]     = std_event_next[isr_pkg::STD_CMD_ERR] | command_error;
      std_event_next[isr_pkg::STD_POWER_ON]    = std_event_next[isr_pkg::STD_POWER_ON] | power_on_pulse;
      std_event_next = std_event_next & isr_pkg::STD_USED_MASK;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         std_event_reg <= 8'h80;
      end else if (clk_en) begin
         std_event_reg <= std_event_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         status_byte_reg <= 8'h00;
      end else if (clk_en) begin
         status_byte_reg <= 8'h00;
         status_byte_reg[isr_pkg::STB_QUES] <= ques_if.summary;
         status_byte_reg[isr_pkg::STB_OPER] <= oper_if.summary;
         status_byte_reg[isr_pkg::STB_STD]  <= |(std_event_reg & std_enable_reg);
         status_byte_reg[isr_pkg::STB_MAV]  <= output_queue_avail;
      end
   end

   assign questionable_conditions = ques_cond_reg;
   assign operation_conditions    = oper_cond_reg;
   assign ques_event_data         = ques_if.event_bits;
   assign oper_event_data         = oper_if.event_bits;
   assign standard_events         = std_event_reg;
   assign status_byte             = status_byte_reg;
   assign error_log_pulse         = error_log_reg;
   assign input_relays_open       = relay_open_reg;

   a_trig_fast: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && trigger_event && scan_active && !reset_cmd && !power_on_pulse
      |=> questionable_conditions[isr_pkg::QUES_TRIG_FAST])
      else $error("trigger too fast not flagged");
   a_reset_setup: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reset_cmd |=> questionable_conditions[isr_pkg::QUES_SETUP_CHG])
      else $error("reset did not set setup changed");
   a_relay_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      input_relays_open && !reset_cmd |=> input_relays_open)
      else $error("relays closed without reset");
   a_reserved_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
      !operation_conditions[isr_pkg::OPER_PLUGON_TRIG])
      else $error("reserved operation bit driven");
   a_unused_std: assert property (@(posedge sys_clk) disable iff (!nrst)
      !standard_events[isr_pkg::STD_REQ_CONTROL] && !standard_events[isr_pkg::STD_USER_REQ])
      else $error("unused standard bit set");
   a_half_full: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && (buffer_count >= isr_pkg::BUF_HALF_LEVEL) |=> operation_conditions[isr_pkg::OPER_HALF_FULL])
      else $error("half full not shown");
   a_cmd_error: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && command_error |=> standard_events[isr_pkg::STD_CMD_ERR] ##1 (!clk_en || status_byte[isr_pkg::STB_STD]
      || !std_enable_reg[isr_pkg::STD_CMD_ERR] || std_event_read || clear_all))
      else $error("command error not reported");
   a_measuring: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && trigger_initiated |=> operation_conditions[isr_pkg::OPER_MEASURING])
      else $error("measuring not set on initiate");
   a_oper_summary: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && ((oper_event_data & oper_enable_reg) != 16'h0000) |=> status_byte[isr_pkg::STB_OPER])
      else $error("enabled operation event not in status byte");
endmodule : isr_status_top

//--- testbench/isr_host_model.sv
// Host model that polls the status byte and reads the flagged event registers
`timescale 1ns/10ps
module isr_host_model (
   input  wire logic       sys_clk,
   input  wire logic       poll,
   input  wire logic [7:0] status_byte,
   output logic      [2:0] event_read = 3'h0
);
   // One read per poll, a cycle after the summary is seen, so reads never collide with a poll
   always @(posedge sys_clk) begin
      event_read <= poll ? {status_byte[isr_pkg::STB_OPER], status_byte[isr_pkg::STB_STD],
                            status_byte[isr_pkg::STB_QUES]} : 3'h0;
   end
endmodule : isr_host_model

//--- testbench/instrument_status_reporting_tb_top.sv
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module instrument_status_reporting_tb_top;
   typedef struct packed {logic [27:0] pm; logic [16:0] bc; logic [1:0] sel; logic [3:0] bp; logic ex;} isr_row_t;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        poll = 1'b0;
   logic        ce = 1'b1;
   logic [27:0] p = 28'h0000000;
   logic [16:0] bc = 17'h00000;
   logic [6:0]  wr = 7'h00;
   logic [15:0] wd = 16'h0000;
   logic [2:0]  rd;
   logic [15:0] qc, oc, qe, oe;
   logic [7:0]  se, sb;
   logic        elog, relay;
   int          fail_count = 0;
   int          samples_checked = 0;
   isr_row_t    rows [22];
   always #5 sys_clk = ~sys_clk;
   isr_status_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(ce), .power_on_pulse(p[0]), .reset_cmd(p[1]),
      .preset_cmd(p[2]), .clear_status_cmd(p[3]), .cal_checksum_fail(p[4]), .trigger_event(p[5]), .scan_active(p[6]),
      .scan_pass_done(p[7]), .buffer_store(p[8]), .buffer_count(bc), .acq_mem_overflow(p[9]),
      .overvoltage_detect(p[10]), .protect_enabled(p[11]), .setup_changed(p[12]), .cal_setup_done(p[13]),
      .tare_calibration_command(p[14]), .setup_cal_command(p[15]), .cal_query(p[16]), .self_cal_start(p[17]),
      .self_cal_done(p[18]), .trigger_initiated(p[19]), .trigger_idle(p[20]), .alg_interrupt(p[21]),
      .opc_done(p[22]), .query_error(p[23]), .device_error(p[24]), .execution_error(p[25]), .command_error(p[26]),
      .output_queue_avail(p[27]), .ques_ptr_wr_data(wd), .ques_ptr_wr(wr[0]), .ques_ntr_wr_data(wd),
      .ques_ntr_wr(wr[1]), .ques_enable_wr_data(wd), .ques_enable_wr(wr[2]), .oper_ptr_wr_data(wd),
      .oper_ptr_wr(wr[3]), .oper_ntr_wr_data(wd), .oper_ntr_wr(wr[4]), .oper_enable_wr_data(wd),
      .oper_enable_wr(wr[5]), .std_enable_wr_data(wd[7:0]), .std_enable_wr(wr[6]), .ques_event_read(rd[0]),
      .oper_event_read(rd[2]), .std_event_read(rd[1]), .questionable_conditions(qc), .operation_conditions(oc),
      .ques_event_data(qe), .oper_event_data(oe), .standard_events(se), .status_byte(sb), .error_log_pulse(elog),
      .input_relays_open(relay));
   isr_host_model u_host (.sys_clk(sys_clk), .poll(poll), .status_byte(sb), .event_read(rd));
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   // Inputs held for one cycle, then n extra edges for the deeper pipeline stages
   task automatic step(input logic [27:0] m, input int n);
      @(posedge sys_clk) p <= m;
      @(posedge sys_clk) p <= 28'h0000000;
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : step
   task automatic wreg(input int i, input logic [15:0] d);
      @(posedge sys_clk) begin
         wr[i] <= 1'b1;
         wd <= d;
      end
      @(posedge sys_clk) wr <= 7'h00;
   endtask : wreg
   initial begin
      #100000;
      fail_count++;
      test_done();
   end
   initial begin
      logic got;
      rows = '{'{28'h0000060, 17'h00000, 2'h0, 4'h9, 1'b1}, '{28'h0000100, 17'h0FDFF, 2'h0, 4'hA, 1'b0},
               '{28'h0000100, 17'h0FE00, 2'h0, 4'hA, 1'b1}, '{28'h0000200, 17'h00000, 2'h0, 4'hC, 1'b1},
               '{28'h0002000, 17'h00000, 2'h0, 4'hD, 1'b0}, '{28'h0001000, 17'h00000, 2'h0, 4'hD, 1'b1},
               '{28'h0004000, 17'h00000, 2'h1, 4'h0, 1'b1}, '{28'h0010000, 17'h00000, 2'h1, 4'h0, 1'b0},
               '{28'h0008000, 17'h00000, 2'h1, 4'h0, 1'b1}, '{28'h0010000, 17'h00000, 2'h1, 4'h0, 1'b0},
               '{28'h0080000, 17'h00000, 2'h1, 4'h4, 1'b1}, '{28'h0100000, 17'h00000, 2'h1, 4'h4, 1'b0},
               '{28'h0000080, 17'h00000, 2'h1, 4'h8, 1'b1}, '{28'h0000080, 17'h00000, 2'h1, 4'h9, 1'b0},
               '{28'h0000000, 17'h08000, 2'h1, 4'hA, 1'b1}, '{28'h0000000, 17'h07FFF, 2'h1, 4'hA, 1'b0},
               '{28'h0200000, 17'h00000, 2'h1, 4'hB, 1'b1}, '{28'h0400000, 17'h00000, 2'h2, 4'h0, 1'b1},
               '{28'h0800000, 17'h00000, 2'h2, 4'h2, 1'b1}, '{28'h1000000, 17'h00000, 2'h2, 4'h3, 1'b1},
               '{28'h2000000, 17'h00000, 2'h2, 4'h4, 1'b1}, '{28'h4000000, 17'h00000, 2'h2, 4'h5, 1'b1}};
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(negedge sys_clk);
      `CHK("ques cond", 16'h2000, qc)
      `CHK("std events", 8'h80, se)
      `CHK("status byte", 8'h00, sb)
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge sys_clk) bc <= rows[i].bc;
         step(rows[i].pm, 0);
         got = rows[i].sel == 2'h0 ? qc[rows[i].bp] : rows[i].sel == 2'h1 ? oc[rows[i].bp] : se[rows[i].bp[2:0]];
         `CHK("row bit", rows[i].ex, got)
      end
      `CHK("unused std", 2'b00, {se[6], se[1]})
      $display("table test done");
      step(28'h0000C00, 0);
      `CHK("overvolt", 2'b11, {qc[11], relay})
      `CHK("err log", 1'b1, elog)
      step(28'h0000012, 0);
      `CHK("reset ques", 17'h04200, {qc, relay})
      `CHK("cal err log", 1'b1, elog)
      `CHK("std cleared", 8'h00, se)
      $display("protection test done");
      step(28'h0000008, 0);
      `CHK("ev clear", 32'h00000000, {qe, oe})
      wreg(5, 16'h0010);
      wreg(6, 16'h0020);
      step(28'h0080000, 2);
      `CHK("oper ev rise", 16'h0010, oe)
      `CHK("stb oper", 1'b1, sb[7])
      step(28'h0100000, 1);
      `CHK("oper ev fall", 16'h0010, oe)
      @(posedge sys_clk) poll <= 1'b1;
      @(posedge sys_clk) poll <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("oper ev read", 16'h0000, oe)
      `CHK("stb after read", 1'b0, sb[7])
      wreg(4, 16'h0010);
      wreg(3, 16'h0000);
      step(28'h0080000, 1);
      `CHK("ptr off", 16'h0000, oe)
      step(28'h0100000, 2);
      `CHK("ntr on", 16'h0010, oe)
      step(28'h4000000, 1);
      `CHK("stb std", 8'hA0, sb)
      step(28'h0000004, 1);
      `CHK("preset", 9'h000, {sb, se[5]})
      step(28'h0000001, 1);
      `CHK("power on std", 1'b1, se[7])
      step(28'h0080000, 1);
      `CHK("default ptr", 16'h0010, oe)
      step(28'h8000000, 0);
      `CHK("stb queue", 1'b1, sb[4])
      @(posedge sys_clk) ce <= 1'b0;
      step(28'h0000004, 1);
      `CHK("frozen preset", 1'b1, se[7])
      @(posedge sys_clk) ce <= 1'b1;
      $display("event test done");
      test_done();
   end
endmodule : instrument_status_reporting_tb_top
